// ---- hw/mccd_exec.sv ----
// execute unit for clear, complement, watchdog clear, compare, adjust, skip
`timescale 1ns/100ps
`include "mccd_consts.svh"
module mccd_exec (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction issue
  input wire mccd_pkg::mccd_instr_t instr,
  // status from the adder, for the adjust op
  input wire logic add_carry,
  input wire logic add_half_carry,
  // state
  output logic [7:0] accumulator,
  output mccd_pkg::mccd_flags_t flags,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic watchdog_clear,
  output logic skip_active,
  output logic [7:0] reg_rd_data
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] regs [0:`MCCD_REG_COUNT-1];
  logic [7:0] next_regs [0:`MCCD_REG_COUNT-1];
  logic [7:0] next_accumulator;
  mccd_pkg::mccd_flags_t next_flags;
  logic next_timeout_flag_n;
  logic next_powerdown_flag_n;
  logic next_watchdog_clear;
  logic next_skip_active;
  logic [7:0] operand;
  logic [8:0] diff;
  logic [7:0] result;
  logic [8:0] adj;
  logic exec;

  // packed decimal correction, low nibble then high
  function automatic logic [8:0] mccd_adjust(input logic [7:0] a,
                                             input logic c,
                                             input logic hc);
    logic [8:0] t;
    t = {1'b0, a};
    if (hc || (t[3:0] > `MCCD_NIB_LIMIT)) begin
      t = t + {1'b0, `MCCD_NIB_FIX};
    end
    if (c || t[8] || (t[7:4] > `MCCD_NIB_LIMIT)) begin
      t = {1'b1, t[7:0] + `MCCD_HI_FIX};
    end
    return t;
  endfunction : mccd_adjust

  assign operand = regs[instr.addr];
  assign reg_rd_data = regs[instr.addr];
  // fetched instruction after a taken skip runs as a no-op
  assign exec = instr.valid && !skip_active;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `MCCD_REG_COUNT; i++) begin
      next_regs[i] = regs[i];
    end
    next_accumulator = accumulator;
    next_flags = flags;
    next_timeout_flag_n = timeout_flag_n;
    next_powerdown_flag_n = powerdown_flag_n;
    next_watchdog_clear = 1'b0;
    next_skip_active = 1'b0;
    diff = {1'b0, operand} + {1'b0, ~accumulator} + 9'h001;
    adj = mccd_adjust(accumulator, add_carry, add_half_carry);
    result = 8'h00;
    if (exec) begin
      unique case (instr.op)
        mccd_pkg::MCCD_OP_CLEAR: begin
          next_regs[instr.addr] = 8'h00;
          next_flags.zero = 1'b1;
        end
        mccd_pkg::MCCD_OP_COMPLEMENT: begin
          result = ~operand;
          next_flags.zero = (result == 8'h00);
          if (instr.dest) begin
            next_regs[instr.addr] = result;
          end else begin
            next_accumulator = result;
          end
        end
        mccd_pkg::MCCD_OP_WDT_CLEAR: begin
          // the counter lives outside; this pulse zeroes it and prescaler
          next_watchdog_clear = 1'b1;
          next_timeout_flag_n = 1'b1;
          next_powerdown_flag_n = 1'b1;
        end
        mccd_pkg::MCCD_OP_COMPARE: begin
          // result dropped, nothing but flags written
          next_flags.zero = (diff[7:0] == 8'h00);
          next_flags.carry = diff[8];
        end
        mccd_pkg::MCCD_OP_DECIMAL: begin
          // only right after an add; half carry comes from that add
          next_accumulator = adj[7:0];
          next_flags.carry = adj[8];
        end
        mccd_pkg::MCCD_OP_DEC_SKIP: begin
          result = operand - `MCCD_ONE;
          if (instr.dest) begin
            next_regs[instr.addr] = result;
          end else begin
            next_accumulator = result;
          end
          next_skip_active = (result == 8'h00);
        end
        mccd_pkg::MCCD_OP_NONE: begin
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `MCCD_REG_COUNT; i++) begin
        regs[i] <= 8'h00;
      end
      accumulator <= `MCCD_ACC_RESET;
      flags <= '0;
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1;
      watchdog_clear <= 1'b0;
      skip_active <= 1'b0;
    end else begin
      for (int i = 0; i < `MCCD_REG_COUNT; i++) begin
        regs[i] <= next_regs[i];
      end
      accumulator <= next_accumulator;
      flags <= next_flags;
      timeout_flag_n <= next_timeout_flag_n;
      powerdown_flag_n <= next_powerdown_flag_n;
      watchdog_clear <= next_watchdog_clear;
      skip_active <= next_skip_active;
    end
  end
endmodule : mccd_exec

// ---- include/mccd_consts.svh ----
// constants for the clear, compare and decimal execute block
// Overview of operation
// - clear op zeroes any register 0..63, sets zero flag, one cycle
// - complement op inverts register, zero flag from result, one cycle
// - destination bit 0 writes accumulator, 1 writes register back
// - watchdog clear zeroes counter and prescaler, sets both status flags
// - compare forms register minus accumulator, updates zero and carry
// - compare keeps accumulator and register unchanged, flags only
// - decimal adjust converts accumulator sum to packed decimal, carry only
// - decrement-skip subtracts one, writes destination, skips on zero
// - taken skip discards fetched instruction, runs a no-op, two cycles
`ifndef MCCD_CONSTS_SVH
`define MCCD_CONSTS_SVH
`define MCCD_DATA_W 8
`define MCCD_ADDR_W 6
`define MCCD_REG_COUNT 64
`define MCCD_ACC_RESET 8'h00
`define MCCD_NIB_LIMIT 4'h9
`define MCCD_NIB_FIX 8'h06
`define MCCD_HI_FIX 8'h60
`define MCCD_ONE 8'h01
`endif

// ---- include/mccd_pkg.sv ----
// types of the clear, compare and decimal execute block
package mccd_pkg;
  typedef enum logic [2:0] {
    MCCD_OP_NONE,
    MCCD_OP_CLEAR,
    MCCD_OP_COMPLEMENT,
    MCCD_OP_WDT_CLEAR,
    MCCD_OP_COMPARE,
    MCCD_OP_DECIMAL,
    MCCD_OP_DEC_SKIP
  } mccd_op_t;
  typedef struct packed {
    logic valid;
    mccd_op_t op;
    logic [5:0] addr;
    logic dest;
  } mccd_instr_t;
  typedef struct packed {
    logic zero;
    logic carry;
    logic half_carry;
  } mccd_flags_t;
endpackage : mccd_pkg

// ---- verification/mccd_exec_asserts.sv ----
// port checker of the execute block
`timescale 1ns/100ps
module mccd_exec_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire mccd_pkg::mccd_instr_t instr,
  input wire logic add_carry,
  input wire logic add_half_carry,
  input wire logic [7:0] accumulator,
  input wire mccd_pkg::mccd_flags_t flags,
  input wire logic timeout_flag_n,
  input wire logic powerdown_flag_n,
  input wire logic watchdog_clear,
  input wire logic skip_active,
  input wire logic [7:0] reg_rd_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // op code only when taken, so discarded slots stay quiet
  wire logic [2:0] k = instr.valid & ~skip_active ? instr.op : 3'h0;
  wire logic [7:0] r = reg_rd_data;
  wire logic [7:0] a = accumulator;
  a_clear_zero: assert property (k == 3'h1 |=> flags.zero)
    else $error("clear op zero flag low");
  a_comp_acc: assert property (
    k == 3'h2 && !instr.dest |=> a == ~$past(r))
    else $error("complement result wrong");
  a_wdt_status: assert property (
    k == 3'h3 |=> watchdog_clear && timeout_flag_n && powerdown_flag_n)
    else $error("watchdog clear wrong");
  a_cmp_flags: assert property (
    k == 3'h4 |=> flags.carry == ($past(r) >= $past(a)) &&
    flags.zero == ($past(r) == $past(a)))
    else $error("compare flags wrong");
  a_cmp_keep: assert property (k == 3'h4 |=> $stable(a))
    else $error("compare changed accumulator");
  a_daa_carry: assert property (
    k == 3'h5 && add_carry |=> flags.carry && $stable(flags.zero))
    else $error("adjust carry wrong");
  a_skip_zero: assert property (
    k == 3'h6 |=> skip_active == ($past(r) == 8'h01))
    else $error("skip decision wrong");
  a_skip_once: assert property (skip_active |=> !skip_active)
    else $error("skip longer than one cycle");
  c_skip: cover property (k == 3'h6 ##1 skip_active);
  c_adjust: cover property (k == 3'h5);
  c_cmp: cover property (k == 3'h4 ##1 flags.carry);
endmodule : mccd_exec_asserts
bind mccd_exec mccd_exec_asserts i_chk (.*);

// ---- verification/mccd_exec_test.sv ----
// self-checking bench of the execute block
`timescale 1ns/100ps
module mccd_exec_test;
  logic clk = 0, rst = 1, cy = 0, hc = 0, seen = 0, mz = 0, mc = 0, ms = 0;
  logic to_n, pd_n, wdc, skp;
  logic [7:0] acc, rd, ma = 8'h00, m [64] = '{default: 8'h00};
  logic [13:0] q [$];
  logic [13:0] e;
  logic [7:0] qr [$];
  logic [9:0] dir [10] = '{10'h0FE, 10'h17F, 10'h37F, 10'h17F, 10'h37F,
    10'h17E, 10'h17E, 10'h180, 10'h27E, 10'h37E};
  mccd_pkg::mccd_instr_t instr = '0;
  mccd_pkg::mccd_flags_t fl;
  int n_fail = 0, num_checks = 0, i;
  mccd_exec i_dut (.clk(clk), .rst(rst), .instr(instr), .add_carry(cy),
    .add_half_carry(hc), .accumulator(acc), .flags(fl),
    .timeout_flag_n(to_n), .powerdown_flag_n(pd_n),
    .watchdog_clear(wdc), .skip_active(skp), .reg_rd_data(rd));
  initial forever #50 clk = ~clk;
  task check(logic [13:0] s, logic [13:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task complete_run;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task run(logic [2:0] o, logic [5:0] ad, logic d);
    logic [8:0] t;
    logic [7:0] v, r;
    logic w, c, h;
    c = 1'($urandom);
    h = 1'($urandom);
    @(posedge clk);
    instr <= '{1'b1, mccd_pkg::mccd_op_t'(o), ad, d};
    cy <= c;
    hc <= h;
    r = m[ad];
    qr.push_back(r);
    v = r;
    w = 0;
    if (ms) ms = 0;
    else begin
      case (o)
        3'h1: begin m[ad] = 8'h00; mz = 1; end
        3'h2: begin v = ~r; mz = v == 8'h00; end
        3'h3: w = 1;
        3'h4: begin mz = r == ma; mc = r >= ma; end
        3'h5: begin
          t = ma + ((h || ma[3:0] > 4'h9) ? 9'h006 : 9'h000);
          mc = c || t[8] || t[7:4] > 4'h9;
          ma = t[7:0] + (mc ? 8'h60 : 8'h00);
        end
        3'h6: begin v = r - 8'h01; ms = v == 8'h00; end
        default: w = 0;
      endcase
      if (o == 3'h2 || o == 3'h6) begin
        if (d) m[ad] = v;
        else ma = v;
      end
    end
    q.push_back({ma, mz, mc, ms, w, 2'b11});
  endtask : run
  always @(posedge clk) seen <= instr.valid;
  always @(negedge clk) begin
    if (seen && q.size() > 0) begin
      e = q.pop_front();
      check(acc, e[13:6]);
      check(fl.zero, e[5]);
      check(fl.carry, e[4]);
      check(skp, e[3]);
      check({wdc, to_n, pd_n}, e[2:0]);
    end
    if (instr.valid && qr.size() > 0) begin
      check(rd, qr.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h11f6d36a));
    repeat (12) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 10; i++) run(dir[i][9:7], dir[i][6:1], dir[i][0]);
    for (i = 0; i < 400; i++)
      run(3'($urandom_range(6)), 6'h3C + 6'($urandom_range(3)), 1'($urandom));
    @(posedge clk);
    instr.valid <= 0;
    repeat (3) @(posedge clk);
    complete_run();
  end
  // run needs about 430 cycles, so this leaves a wide margin
  initial begin
    #300000;
    n_fail++;
    complete_run();
  end
endmodule : mccd_exec_test
